// [core/aemp_port.sv]
`timescale 1ns/1ps
module aemp_port
(
  input  wire logic                             core_clk,
  input  wire logic                             reset,
  input  wire logic                             dma_valid,
  input  wire aemp_pkg::aemp_req_s              dma_req,
  input  wire logic [aemp_pkg::PRIO_W-1:0]      dma_prio,
  output logic                                  dma_ready,
  input  wire logic                             cpu_valid,
  input  wire aemp_pkg::aemp_req_s              cpu_req,
  input  wire logic [aemp_pkg::PRIO_W-1:0]      cpu_prio,
  output logic                                  cpu_ready,
  output logic                                  rd_done,
  output logic [aemp_pkg::DATA_W-1:0]           rd_data,
  output logic                                  wr_done,
  input  wire aemp_pkg::aemp_space_cfg_s        space_config [aemp_pkg::SPACES],
  input  wire logic                             wait_polarity,
  output logic                                  busy,
  output logic [aemp_pkg::WORD_ADDR_W-1:0]      word_addr_bus,
  output logic [aemp_pkg::LANE_W-1:0]           byte_lane_addr,
  output logic [aemp_pkg::SPACES-1:0]           space_select_n,
  output logic                                  rd_wr_select,
  output logic                                  output_enable_n,
  output logic                                  write_enable_n,
  input  wire logic [aemp_pkg::DATA_W-1:0]      ext_data_in,
  output logic [aemp_pkg::DATA_W-1:0]           ext_data_out,
  output logic                                  ext_data_oe,
  input  wire logic                             ext_wait_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // core_clk is the primary pll output through sysclk_div_six; no pin clock
  typedef struct packed {
    aemp_pkg::aemp_state_e          st;
    logic [aemp_pkg::CNT_W-1:0]     cnt;
    aemp_pkg::aemp_req_s            req;
    aemp_pkg::aemp_space_cfg_s      cfg;
    logic [aemp_pkg::DATA_W-1:0]    rdata;
    logic                           rd_done;
    logic                           wr_done;
    logic [aemp_pkg::SYNC_STAGES-1:0] wsync;
    logic [aemp_pkg::CNT_W+1:0]     acc_len;
  } aemp_port_s;

  aemp_port_s r;
  aemp_port_s next_r;

  logic                fwd_valid;
  aemp_pkg::aemp_req_s fwd_req;
  logic                fwd_ready;
  logic                wait_active;
  aemp_pkg::aemp_phase_s ph;

  aemp_request_switch u_switch
  (
    .core_clk  (core_clk),
    .reset     (reset),
    .dma_valid (dma_valid),
    .dma_req   (dma_req),
    .dma_prio  (dma_prio),
    .dma_ready (dma_ready),
    .cpu_valid (cpu_valid),
    .cpu_req   (cpu_req),
    .cpu_prio  (cpu_prio),
    .cpu_ready (cpu_ready),
    .fwd_valid (fwd_valid),
    .fwd_req   (fwd_req),
    .fwd_ready (fwd_ready)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // only the second sync stage is read, polarity applied after it
  assign wait_active = (r.wsync[1] == wait_polarity) && r.cfg.ext_wait_enable;
  assign fwd_ready   = (r.st == aemp_pkg::AEMP_IDLE);
  assign ph          = r.req.write ? r.cfg.wr : r.cfg.rd;

  always_comb
  begin
    next_r         = r;
    next_r.wsync   = {r.wsync[0], ext_wait_in};
    next_r.rd_done = 1'b0;
    next_r.wr_done = 1'b0;
    // cycles spent in the current access, so its programmed length can be checked
    next_r.acc_len = ((r.st == aemp_pkg::AEMP_SETUP) || (r.st == aemp_pkg::AEMP_STROBE)
                     || (r.st == aemp_pkg::AEMP_HOLD)) ? r.acc_len + 1'b1 : '0;
    case (r.st)
      aemp_pkg::AEMP_IDLE:
      begin
        if (fwd_valid)
        begin
          next_r.req = fwd_req;
          next_r.cfg = space_config[fwd_req.space];
          next_r.cnt = '0;
          next_r.st  = aemp_pkg::AEMP_SETUP;
        end
      end
      aemp_pkg::AEMP_SETUP:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= ph.setup)
        begin
          next_r.cnt = '0;
          next_r.st  = aemp_pkg::AEMP_STROBE;
        end
      end
      aemp_pkg::AEMP_STROBE:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= ph.strobe && !wait_active)
        begin
          next_r.cnt = '0;
          next_r.st  = aemp_pkg::AEMP_HOLD;
          if (!r.req.write)
          begin
            next_r.rdata = ext_data_in;
          end
        end
        else if (r.cnt >= ph.strobe)
        begin
          next_r.cnt = r.cnt;
        end
      end
      aemp_pkg::AEMP_HOLD:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= ph.hold)
        begin
          next_r.cnt     = '0;
          next_r.rd_done = !r.req.write;
          next_r.wr_done = r.req.write;
          next_r.st      = aemp_pkg::AEMP_TURN;
        end
      end
      aemp_pkg::AEMP_TURN:
      begin
        next_r.cnt = r.cnt + 1'b1;
        if (r.cnt >= aemp_pkg::CNT_W'(r.cfg.turnaround))
        begin
          next_r.cnt = '0;
          next_r.st  = aemp_pkg::AEMP_IDLE;
        end
      end
      default:
      begin
        next_r.st = aemp_pkg::AEMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic in_access;
  logic in_strobe;

  always_comb
  begin
    in_access       = (r.st == aemp_pkg::AEMP_SETUP) || (r.st == aemp_pkg::AEMP_STROBE)
                      || (r.st == aemp_pkg::AEMP_HOLD);
    in_strobe       = (r.st == aemp_pkg::AEMP_STROBE);
    word_addr_bus   = r.req.word_addr;
    byte_lane_addr  = r.req.lane;
    space_select_n  = aemp_pkg::SELECT_IDLE;
    if (r.cfg.strobe_select ? in_strobe : in_access)
    begin
      space_select_n[r.req.space] = 1'b0;
    end
    rd_wr_select    = !(in_access && r.req.write);
    output_enable_n = !(in_strobe && !r.req.write);
    write_enable_n  = !(in_strobe && r.req.write);
    ext_data_out    = r.req.wdata;
    ext_data_oe     = in_access && r.req.write;
    rd_data         = r.rdata;
    rd_done         = r.rd_done;
    wr_done         = r.wr_done;
    busy            = !fwd_ready;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_idle_pins_high : assert property (@(posedge core_clk) disable iff (reset)
    (r.st == aemp_pkg::AEMP_IDLE) |-> (&space_select_n && output_enable_n && write_enable_n))
    else $error("strobes active while idle");
  a_oe_read_only : assert property (@(posedge core_clk) disable iff (reset)
    !output_enable_n |-> (in_strobe && !r.req.write))
    else $error("output enable outside read strobe");
  a_we_write_only : assert property (@(posedge core_clk) disable iff (reset)
    !write_enable_n |-> (in_strobe && r.req.write))
    else $error("write enable outside write strobe");
  a_rw_stable : assert property (@(posedge core_clk) disable iff (reset)
    (in_access && !$past(in_access)) |-> (rd_wr_select == !r.req.write))
    else $error("read/write select wrong at access start");
  a_single_access : assert property (@(posedge core_clk) disable iff (reset)
    (r.st != aemp_pkg::AEMP_IDLE) |-> !dma_ready && !cpu_ready)
    else $error("request taken while busy");
  a_one_select : assert property (@(posedge core_clk) disable iff (reset)
    $countones(~space_select_n) <= 1)
    else $error("more than one select active");
  a_wait_holds_strobe : assert property (@(posedge core_clk) disable iff (reset)
    (in_strobe && wait_active) |=> in_strobe)
    else $error("strobe ended under wait");
  a_ss_select : assert property (@(posedge core_clk) disable iff (reset)
    (r.cfg.strobe_select && !in_strobe) |-> &space_select_n)
    else $error("select outside strobe in strobe-select mode");
  a_data_drive : assert property (@(posedge core_clk) disable iff (reset)
    ext_data_oe |-> !rd_wr_select)
    else $error("bus driven during read");
  a_rw_whole : assert property (@(posedge core_clk) disable iff (reset)
    in_access |-> (rd_wr_select == !r.req.write))
    else $error("read/write select changed inside access");
  a_normal_select : assert property (@(posedge core_clk) disable iff (reset)
    (!r.cfg.strobe_select && in_access) |-> !space_select_n[r.req.space])
    else $error("select inactive inside normal-mode access");
  a_strobe_select : assert property (@(posedge core_clk) disable iff (reset)
    (r.cfg.strobe_select && in_strobe) |-> !space_select_n[r.req.space])
    else $error("select inactive in strobe-select strobe");
  a_addr_held : assert property (@(posedge core_clk) disable iff (reset)
    (in_access && $past(in_access)) |-> ($stable(word_addr_bus) && $stable(byte_lane_addr)))
    else $error("address moved inside access");
  a_wdata_held : assert property (@(posedge core_clk) disable iff (reset)
    (ext_data_oe && $past(ext_data_oe)) |-> $stable(ext_data_out))
    else $error("write data moved while driven");
  a_cfg_frozen : assert property (@(posedge core_clk) disable iff (reset)
    (in_access && $past(in_access)) |-> $stable(r.cfg))
    else $error("timing changed inside access");
  a_setup_end : assert property (@(posedge core_clk) disable iff (reset)
    (r.st == aemp_pkg::AEMP_SETUP && r.cnt >= ph.setup) |=> in_strobe)
    else $error("strobe late after setup");
  a_strobe_min : assert property (@(posedge core_clk) disable iff (reset)
    (in_strobe && r.cnt < ph.strobe) |=> in_strobe)
    else $error("strobe shorter than programmed");
  a_wait_release : assert property (@(posedge core_clk) disable iff (reset)
    (in_strobe && r.cnt >= ph.strobe && !wait_active) |=> (r.st == aemp_pkg::AEMP_HOLD))
    else $error("strobe kept without wait");
  a_hold_end : assert property (@(posedge core_clk) disable iff (reset)
    (r.st == aemp_pkg::AEMP_HOLD && r.cnt >= ph.hold) |=> (rd_done || wr_done))
    else $error("no done after hold");
  a_turn_min : assert property (@(posedge core_clk) disable iff (reset)
    (r.st == aemp_pkg::AEMP_TURN && r.cnt < aemp_pkg::CNT_W'(r.cfg.turnaround))
    |=> (r.st == aemp_pkg::AEMP_TURN))
    else $error("turnaround shorter than programmed");
  a_turn_end : assert property (@(posedge core_clk) disable iff (reset)
    (r.st == aemp_pkg::AEMP_TURN && r.cnt >= aemp_pkg::CNT_W'(r.cfg.turnaround)) |=> fwd_ready)
    else $error("not idle after turnaround");
  a_done_pulse : assert property (@(posedge core_clk) disable iff (reset)
    (rd_done || wr_done) |=> !(rd_done || wr_done))
    else $error("done longer than one cycle");
  a_idle_quiet : assert property (@(posedge core_clk) disable iff (reset)
    fwd_ready |-> (!ext_data_oe && rd_wr_select))
    else $error("bus driven while idle");
  a_access_len : assert property (@(posedge core_clk) disable iff (reset)
    (r.st == aemp_pkg::AEMP_HOLD && r.cnt >= ph.hold && !r.cfg.ext_wait_enable)
    |-> (r.acc_len == ({2'b00, ph.setup} + {2'b00, ph.strobe} + {2'b00, ph.hold} + 8'h02)))
    else $error("access length differs from programmed");

  c_read : cover property (@(posedge core_clk) disable iff (reset) rd_done);
  c_ss_read : cover property (@(posedge core_clk) disable iff (reset)
    rd_done && r.cfg.strobe_select);
  c_write : cover property (@(posedge core_clk) disable iff (reset) wr_done);
  c_wait : cover property (@(posedge core_clk) disable iff (reset) in_strobe && wait_active);
  c_clash : cover property (@(posedge core_clk) disable iff (reset)
    dma_valid && cpu_valid && fwd_ready);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // select decode needs one select per space code
  if (aemp_pkg::SPACES != (1 << aemp_pkg::SPACE_W))
  begin : g_bad_spaces
    $error("space count does not match space code width");
  end
  // the wait path reads stage two; a single stage would skip synchronising
  if (aemp_pkg::SYNC_STAGES != 2)
  begin : g_bad_sync
    $error("wait synchroniser needs two stages");
  end
  // turnaround is widened into the phase counter, never cut
  if (aemp_pkg::TA_W > aemp_pkg::CNT_W)
  begin : g_bad_turn
    $error("turnaround wider than phase counter");
  end

endmodule // aemp_port

// [core/aemp_pkg.sv]
package aemp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_ADDR_W = 22;
  localparam int unsigned LANE_W      = 2;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SPACES      = 4;
  localparam int unsigned SPACE_W     = 2;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned TA_W        = 2;
  localparam int unsigned PRIO_W      = 3;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SPACES-1:0] SELECT_IDLE = 4'hf;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AEMP_IDLE   = 3'b000,
    AEMP_SETUP  = 3'b001,
    AEMP_STROBE = 3'b010,
    AEMP_HOLD   = 3'b011,
    AEMP_TURN   = 3'b100
  } aemp_state_e;

  typedef struct packed {
    logic                   write;
    logic [SPACE_W-1:0]     space;
    logic [WORD_ADDR_W-1:0] word_addr;
    logic [LANE_W-1:0]      lane;
    logic [DATA_W-1:0]      wdata;
  } aemp_req_s;

  typedef struct packed {
    logic [CNT_W-1:0] setup;
    logic [CNT_W-1:0] strobe;
    logic [CNT_W-1:0] hold;
  } aemp_phase_s;

  typedef struct packed {
    logic        strobe_select;
    logic        ext_wait_enable;
    aemp_phase_s rd;
    aemp_phase_s wr;
    logic [TA_W-1:0] turnaround;
  } aemp_space_cfg_s;

endpackage

// [core/aemp_request_switch.sv]
`timescale 1ns/1ps
module aemp_request_switch
(
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       dma_valid,
  input  wire aemp_pkg::aemp_req_s        dma_req,
  input  wire logic [aemp_pkg::PRIO_W-1:0] dma_prio,
  output logic                            dma_ready,
  input  wire logic                       cpu_valid,
  input  wire aemp_pkg::aemp_req_s        cpu_req,
  input  wire logic [aemp_pkg::PRIO_W-1:0] cpu_prio,
  output logic                            cpu_ready,
  output logic                            fwd_valid,
  output aemp_pkg::aemp_req_s             fwd_req,
  input  wire logic                       fwd_ready
);

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // lower value ranks higher; ties go to the dma requester
  logic pick_dma;

  always_comb
  begin
    pick_dma = dma_valid && (!cpu_valid || (dma_prio <= cpu_prio));
    fwd_valid = dma_valid || cpu_valid;
    fwd_req   = pick_dma ? dma_req : cpu_req;
    dma_ready = fwd_ready && pick_dma;
    cpu_ready = fwd_ready && !pick_dma && cpu_valid;
  end

  a_tie_goes_dma : assert property (@(posedge core_clk) disable iff (reset)
    (dma_valid && cpu_valid && dma_prio == cpu_prio && fwd_ready) |-> dma_ready && !cpu_ready)
    else $error("tie not given to dma");
  a_one_grant : assert property (@(posedge core_clk) disable iff (reset)
    !(dma_ready && cpu_ready))
    else $error("both requesters granted");

endmodule // aemp_request_switch

// [verif/aemp_sram_model.sv]
`timescale 1ns/1ps
module aemp_sram_model
(
  input  wire logic        core_clk,
  input  wire logic [21:0] word_addr_bus,
  input  wire logic [1:0]  byte_lane_addr,
  input  wire logic [3:0]  space_select_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        wait_pol,
  input  wire logic [3:0]  wait_len,
  output logic [7:0]       ext_data_in,
  output logic             ext_wait_in
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic [3:0] wcnt;
  logic [1:0] sp;
  logic       strobe;
  logic       sel;

  assign sel = space_select_n != 4'hf;
  assign sp = !space_select_n[0] ? 2'h0 : !space_select_n[1] ? 2'h1 :
              !space_select_n[2] ? 2'h2 : 2'h3;
  assign strobe = !(output_enable_n && write_enable_n);
  // released bus toggles, so a stale byte never passes for read data
  assign ext_data_in = (!output_enable_n && sel) ?
                       mem[{sp, word_addr_bus[3:0], byte_lane_addr}] : ~last;
  // wait held active for wait_len cycles from strobe start
  assign ext_wait_in = (strobe && wcnt < wait_len) ? wait_pol : ~wait_pol;

  always @(negedge core_clk)
  begin
    wcnt <= strobe ? wcnt + {3'h0, wcnt != 4'hf} : 4'h0;
    last <= ext_data_in;
    if (!write_enable_n && sel)
      mem[{sp, word_addr_bus[3:0], byte_lane_addr}] <= ext_data_out;
  end
endmodule // aemp_sram_model

// [verif/test_aemp_port.sv]
`timescale 1ns/1ps
module test_aemp_port;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                      core_clk, reset, dma_valid, cpu_valid, wait_polarity;
  logic                      dma_ready, cpu_ready, rd_done, wr_done, busy, rd_wr_select;
  logic                      output_enable_n, write_enable_n, ext_data_oe, ext_wait_in;
  logic [2:0]                dma_prio, cpu_prio;
  logic [3:0]                space_select_n, wlen;
  logic [7:0]                rd_data, ext_data_in, ext_data_out;
  logic [21:0]               word_addr_bus;
  logic [1:0]                byte_lane_addr;
  aemp_pkg::aemp_req_s       dma_req, cpu_req, cur;
  aemp_pkg::aemp_space_cfg_s cfg [aemp_pkg::SPACES];
  logic [7:0]                shadow [256];
  int                        cyc = 0, t_take, scnt, cscnt, miscompares = 0, checks_done = 0;

  aemp_port u_aemp_port (.core_clk(core_clk), .reset(reset), .dma_valid(dma_valid),
    .dma_req(dma_req), .dma_prio(dma_prio), .dma_ready(dma_ready), .cpu_valid(cpu_valid),
    .cpu_req(cpu_req), .cpu_prio(cpu_prio), .cpu_ready(cpu_ready), .rd_done(rd_done),
    .rd_data(rd_data), .wr_done(wr_done), .space_config(cfg), .wait_polarity(wait_polarity),
    .busy(busy), .word_addr_bus(word_addr_bus), .byte_lane_addr(byte_lane_addr),
    .space_select_n(space_select_n), .rd_wr_select(rd_wr_select),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .ext_wait_in(ext_wait_in));

  aemp_sram_model u_aemp_sram_model (.core_clk(core_clk), .word_addr_bus(word_addr_bus),
    .byte_lane_addr(byte_lane_addr), .space_select_n(space_select_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .ext_data_out(ext_data_out), .wait_pol(wait_polarity), .wait_len(wlen),
    .ext_data_in(ext_data_in), .ext_wait_in(ext_wait_in));

  // ----------------------------------------------------------------
  // compare and access tasks
  // ----------------------------------------------------------------
  task automatic check_pin(input string n, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_count(input string n, input int g, input int e);
    checks_done++;
    if (g != e)
    begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // both: loser stays pending, taken by the next call
  task automatic access(input bit dma, input aemp_pkg::aemp_req_s r, input bit both,
                        input bit waited);
    aemp_pkg::aemp_phase_s ph;
    int k;
    ph = r.write ? cfg[r.space].wr : cfg[r.space].rd;
    k = 0;
    dma_req = r;
    cpu_req = r;
    dma_valid = dma || both;
    cpu_valid = !dma || both;
    #1;
    while (!(dma ? dma_ready : cpu_ready) && k < 300)
    begin
      @(negedge core_clk);
      #1;
      k++;
    end
    check_pin("grant", {dma_ready, cpu_ready}, dma ? 2'h2 : 2'h1);
    cur = r;
    scnt = 0;
    cscnt = 0;
    @(negedge core_clk);
    t_take = cyc;
    dma_valid = dma_valid && !dma;
    cpu_valid = cpu_valid && dma;
    k = 0;
    while (!(rd_done || wr_done) && k < 300)
    begin
      @(negedge core_clk);
      k++;
    end
    check_pin("done kind", {rd_done, wr_done}, r.write ? 2'h1 : 2'h2);
    if (r.write)
      shadow[{r.space, r.word_addr[3:0], r.lane}] = r.wdata;
    else
      check_pin("read data", rd_data, shadow[{r.space, r.word_addr[3:0], r.lane}]);
    if (waited)
      check_pin("wait stretch", scnt > ph.strobe + 1 && scnt < ph.strobe + 11, 1'b1);
    else
    begin
      check_count("strobe", scnt, ph.strobe + 1);
      check_count("select", cscnt, cfg[r.space].strobe_select ? ph.strobe + 1 :
                  ph.setup + ph.strobe + ph.hold + 3);
      check_count("latency", cyc - t_take, ph.setup + ph.strobe + ph.hold + 3);
    end
  endtask

  // ----------------------------------------------------------------
  // pin monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk)
    cyc <= cyc + 1;

  always @(negedge core_clk)
    if (!reset)
    begin
      if (!busy)
        check_pin("idle pins", {space_select_n, output_enable_n, write_enable_n}, 6'h3f);
      else
        check_pin("grant busy", {dma_ready, cpu_ready}, 2'h0);
      if (busy && cfg[cur.space].strobe_select)
        check_pin("ss select", space_select_n != 4'hf,
                  !output_enable_n || !write_enable_n);
      if (space_select_n != 4'hf)
      begin
        cscnt++;
        check_pin("select", space_select_n, 4'(~(4'h1 << cur.space)));
        check_pin("rd_wr", rd_wr_select, !cur.write);
        check_pin("address", {word_addr_bus, byte_lane_addr}, {cur.word_addr, cur.lane});
      end
      if (!output_enable_n || !write_enable_n)
      begin
        scnt++;
        check_pin("strobe kind", {output_enable_n, write_enable_n, ext_data_oe},
                  cur.write ? 3'h5 : 3'h2);
        if (cur.write)
          check_pin("wdata", ext_data_out, cur.wdata);
      end
    end

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // every test is under a hundred cycles; this is far beyond
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    aemp_pkg::aemp_req_s r;
    reset = 1'b1;
    {dma_valid, cpu_valid, wait_polarity, dma_prio, cpu_prio, wlen} = '0;
    dma_req = '0;
    cpu_req = '0;
    for (int s = 0; s < 4; s++)
      cfg[s] = '{s[0], 1'b0, '{6'(s), 6'(s), 6'(3 - s)}, '{6'(3 - s), 6'h2, 6'(s)}, 2'(s)};
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      r = '{1'b1, 2'(s), 22'h3ffff0 | 22'(s), 2'(3 - s), 8'h5a + 8'(s)};
      access(1'b1, r, 1'b0, 1'b0);
      r.write = 1'b0;
      access(1'b0, r, 1'b0, 1'b0);
    end
    $display("test spaces done");
    cfg[0].rd.strobe = 6'h5;
    cfg[0].rd.setup = 6'h3;
    r = '{1'b0, 2'h0, 22'h3ffff0, 2'h3, 8'h0};
    access(1'b1, r, 1'b0, 1'b0);
    $display("test timing change done");
    r = '{1'b1, 2'h1, 22'h000155, 2'h2, 8'hc3};
    access(1'b1, r, 1'b1, 1'b0);
    access(1'b0, r, 1'b0, 1'b0);
    dma_prio = 3'h7;
    access(1'b0, r, 1'b1, 1'b0);
    access(1'b1, r, 1'b0, 1'b0);
    $display("test arbitration done");
    cfg[2].ext_wait_enable = 1'b1;
    wlen = 4'h6;
    r = '{1'b0, 2'h2, 22'h3ffff2, 2'h1, 8'h0};
    for (int p = 0; p < 2; p++)
    begin
      wait_polarity = p[0];
      access(1'b0, r, 1'b0, 1'b1);
    end
    cfg[2].ext_wait_enable = 1'b0;
    access(1'b1, r, 1'b0, 1'b0);
    $display("test wait done");
    print_verdict();
  end
endmodule // test_aemp_port
